// ### core/trv_pkg.sv
/*
 Shared constants and carriers for the thread reset and vector control block.
 Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
package trv_pkg;
	localparam int THREADS = 8;
	localparam int SYNC_W = 3;
	// Register byte offsets
	localparam logic [3:0] VECTOR_OFS = 4'h0;
	localparam logic [3:0] ERROR_OFS = 4'h8;
	localparam logic [3:0] CTRL_OFS = 4'hC;
	// Vector and error register field positions
	localparam int CLR_LSB = 24;
	localparam int ISR_LSB = 16;
	localparam int DIS_LSB = 8;
	localparam int ARM_LSB = 0;
	localparam int MISS_LSB = 24;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	typedef struct packed {
		logic [7:0] clear;
		logic [7:0] isr;
	} trv_strobe_t;
endpackage

// ### core/trv_vector_ctrl.sv
/*
 Per-thread reset, clear and interrupt vectoring with a Wishbone register slave.
 Assumes a single 200 MHz core clock; the reset pin and external interrupt
 inputs may be asynchronous; the opcode decoder reports interrupt returns.
*/
// Behaviour
// - Async reset loads only the bridge flops; other fabric flops reset synchronously from the bridge; no memory is touched here.
// - Reset pin bridged: asserts asynchronously, releases after SYNC_W clocks.
// - Core-clear pin clears every thread, disarms it, vectors it home.
// - Writing one to a clear bit clears exactly those threads, like core clear.
// - Service strobe tells decoder to push PC on stack 7 and vector.
// - Interrupt requests are taken only by armed threads.
// - Requests during service are ignored until the service routine ends.
// - Interrupt return resumes the thread and re-enables its response.
// - A request dropped during service sets that thread's missed flag.
// - Any thread clear disarms that thread.
// - Arm and disarm are radio buttons; simultaneous write gives disarmed.
// - Zero bits written to arm or disarm change nothing.
// - Reading the arm field returns each thread's armed state; the disarm field returns its complement.
// - External inputs optionally resynchronised, then rising/falling edge detected.
// - Vector logic uses its enable delayed one clock by a flop.
// - In each vector flop except arm, set beats reset in the same clock; for arm, disarm and clear beat arm.
// - In-service sets on armed request, clears on return or thread clear.
// - Accepted request pends until its service strobe issues, then retires.
// - Clear strobes use the same pend and retire logic from both sources.
// - Vector register: clear [31:24], request [23:16], disarm [15:8], arm [7:0].
// - Clear wins over register interrupt request for the same thread.
// - Missed flags read in error register bits [31:24], one means missed.
`timescale 1ns/1ps
`default_nettype none
module trv_vector_ctrl #(
	parameter int SYNC_DEPTH = trv_pkg::SYNC_W,
	parameter logic [7:0] XSR_RESYNC = 8'hFF,
	parameter logic [7:0] XSR_RISE = 8'hFF,
	parameter logic [7:0] XSR_FALL = 8'h00
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pins
	input wire logic core_clear_i,
	input wire logic [7:0] xsr_req_i,
	// Decoder
	input wire logic vec_en_i,
	input wire logic [7:0] interrupt_return_op_i,
	output logic [7:0] clear_strobe_o,
	output logic [7:0] isr_strobe_o,
	output logic core_rst_o,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o
);
	// Bridge flops (constant under async reset, clean release) and the delayed enable
	logic [SYNC_DEPTH-1:0] rst_sync_ff;
	logic rst_int;
	logic vec_en_ff;

	// Per-thread state
	logic [7:0] arm_ff;
	logic [7:0] svc_ff;
	logic [7:0] pend_isr_ff;
	logic [7:0] pend_clr_ff;
	logic [7:0] missed_request_flags_ff;

	// Pin conditioning
	logic [7:0] xsr_s1_ff;
	logic [7:0] xsr_s2_ff;
	logic [7:0] xsr_s3_ff;
	logic [7:0] xsr_prev_ff;
	logic [2:0] cla_sync_ff;
	logic cla_ff;
	logic [7:0] xsr_lvl;
	logic [7:0] xsr_evt;

	// Bus decode
	logic wb_req;
	logic wr_vec;
	logic wr_err;
	logic [7:0] wr_clr;
	logic [7:0] wr_isr;
	logic [7:0] wr_dis;
	logic [7:0] wr_arm;
	logic [7:0] wr_miss;
	// Next state
	logic [7:0] nxt_clr;
	logic [7:0] req;
	logic [7:0] take;
	logic [7:0] drop;
	logic [7:0] nxt_arm;
	logic [7:0] nxt_svc;
	logic [7:0] nxt_pend_isr;
	logic [7:0] nxt_pend_clr;
	logic [7:0] nxt_missed;
	logic [7:0] nxt_isr_strobe;
	logic [7:0] nxt_clear_strobe;

	// Byte of a write, gated by its lane select
	function automatic logic [7:0] wr_byte(input logic [31:0] d, input logic s, input logic w);
		wr_byte = (w && s) ? d[7:0] : trv_pkg::ZERO_BYTE;
	endfunction

	// Event from conditioned level; no edge option means level sensitive
	function automatic logic edge_evt(input logic lvl, input logic prev, input logic rise,
		input logic fall);
		if (rise && lvl && !prev)
			edge_evt = 1'b1;
		else if (fall && !lvl && prev)
			edge_evt = 1'b1;
		else if (!rise && !fall)
			edge_evt = lvl;
		else
			edge_evt = 1'b0;
	endfunction

	// Offsets that answer with ack; all others get err
	function automatic logic is_mapped(input logic [3:0] a);
		is_mapped = (a == trv_pkg::VECTOR_OFS) || (a == trv_pkg::ERROR_OFS)
			|| (a == trv_pkg::CTRL_OFS);
	endfunction

	// Read mux; the status word is read-only
	function automatic logic [31:0] rd_word(input logic [3:0] a);
		case (a)
			trv_pkg::VECTOR_OFS: rd_word = {pend_clr_ff, svc_ff, ~arm_ff, arm_ff};
			trv_pkg::ERROR_OFS: rd_word = {missed_request_flags_ff, trv_pkg::ZERO_BYTE,
				trv_pkg::ZERO_BYTE, trv_pkg::ZERO_BYTE};
			trv_pkg::CTRL_OFS: rd_word = {pend_isr_ff, trv_pkg::ZERO_BYTE, trv_pkg::ZERO_BYTE,
				7'h00, cla_ff};
			default: rd_word = trv_pkg::ZERO_WORD;
		endcase
	endfunction

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rst_sync_ff <= '1;
		else
			rst_sync_ff <= {rst_sync_ff[SYNC_DEPTH-2:0], 1'b0};
	end
	assign rst_int = rst_sync_ff[SYNC_DEPTH-1];

	// Registered copy, so the output comes straight from a flop
	always_ff @(posedge clk_i)
	begin
		core_rst_o <= rst_int;
	end

	// First stage may go metastable; only stage 2 reads it
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			xsr_s1_ff <= trv_pkg::ZERO_BYTE;
		else
			xsr_s1_ff <= xsr_req_i;
	end

	// Stages 2 and 3
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
		begin
			xsr_s2_ff <= trv_pkg::ZERO_BYTE;
			xsr_s3_ff <= trv_pkg::ZERO_BYTE;
		end
		else
		begin
			xsr_s2_ff <= xsr_s1_ff;
			xsr_s3_ff <= xsr_s2_ff;
		end
	end

	// Previous level; reset matches the idle low pin, so no false edge
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			xsr_prev_ff <= trv_pkg::ZERO_BYTE;
		else
			xsr_prev_ff <= xsr_lvl;
	end

	// Core clear pin: three stages
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			cla_sync_ff <= 3'h0;
		else
			cla_sync_ff <= {cla_sync_ff[1:0], core_clear_i};
	end

	// Counted once stages 2 and 3 agree; a glitch never reaches the threads
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			cla_ff <= 1'b0;
		else if (cla_sync_ff[1] == cla_sync_ff[2])
			cla_ff <= cla_sync_ff[2];
	end

	// Level counts once stages 2 and 3 agree
	always_comb
	begin
		for (int t = 0; t < trv_pkg::THREADS; t++)
		begin
			if (!XSR_RESYNC[t])
				xsr_lvl[t] = xsr_req_i[t];
			else if (xsr_s2_ff[t] == xsr_s3_ff[t])
				xsr_lvl[t] = xsr_s3_ff[t];
			else
				xsr_lvl[t] = xsr_prev_ff[t];
		end
	end

	// Edge options are fixed per thread at build time
	always_comb
	begin
		for (int t = 0; t < trv_pkg::THREADS; t++)
		begin
			xsr_evt[t] = edge_evt(xsr_lvl[t], xsr_prev_ff[t], XSR_RISE[t], XSR_FALL[t]);
		end
	end

	// Bus decode
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wr_vec = wb_req && wb_we_i && (wb_adr_i == trv_pkg::VECTOR_OFS);
	assign wr_err = wb_req && wb_we_i && (wb_adr_i == trv_pkg::ERROR_OFS);
	assign wr_clr = wr_byte(wb_dat_i[trv_pkg::CLR_LSB +: 8], wb_sel_i[3], wr_vec);
	assign wr_isr = wr_byte(wb_dat_i[trv_pkg::ISR_LSB +: 8], wb_sel_i[2], wr_vec);
	assign wr_dis = wr_byte(wb_dat_i[trv_pkg::DIS_LSB +: 8], wb_sel_i[1], wr_vec);
	assign wr_arm = wr_byte(wb_dat_i[trv_pkg::ARM_LSB +: 8], wb_sel_i[0], wr_vec);
	assign wr_miss = wr_byte(wb_dat_i[trv_pkg::MISS_LSB +: 8], wb_sel_i[3], wr_err);

	// Either clear source; pin clears all threads
	assign nxt_clr = wr_clr | {8{cla_ff}};
	// Clear masks register request only; pin events bypass the clear mask
	assign req = (wr_isr & ~nxt_clr) | xsr_evt;

	// Acceptance needs the delayed enable; a busy thread drops and flags
	always_comb
	begin
		take = trv_pkg::ZERO_BYTE;
		drop = trv_pkg::ZERO_BYTE;
		for (int t = 0; t < trv_pkg::THREADS; t++)
		begin
			if (vec_en_ff && req[t] && arm_ff[t])
			begin
				if (svc_ff[t])
					drop[t] = 1'b1;
				else
					take[t] = 1'b1;
			end
		end
	end

	// Next state; set terms are ORed last so they win over clears, except arm, where disarm and clear win
	always_comb
	begin
		nxt_arm = (arm_ff | wr_arm) & ~wr_dis & ~nxt_clr;
		nxt_svc = take | (svc_ff & ~interrupt_return_op_i & ~nxt_clr);
		nxt_pend_isr = take | (pend_isr_ff & ~isr_strobe_o & ~nxt_clr);
		nxt_pend_clr = nxt_clr | (pend_clr_ff & ~clear_strobe_o);
		nxt_missed = drop | (missed_request_flags_ff & ~wr_miss);
		nxt_isr_strobe = pend_isr_ff & ~isr_strobe_o & ~pend_clr_ff & {8{vec_en_ff}};
		nxt_clear_strobe = pend_clr_ff & ~clear_strobe_o & {8{vec_en_ff}};
	end

	// Enable delayed one clock before the vector logic uses it
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			vec_en_ff <= 1'b0;
		else
			vec_en_ff <= vec_en_i;
	end

	// Arm: disarm and clear outrank arm; zeros change nothing
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			arm_ff <= trv_pkg::ZERO_BYTE;
		else
			arm_ff <= nxt_arm;
	end

	// In service: set outranks return and clear
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			svc_ff <= trv_pkg::ZERO_BYTE;
		else
			svc_ff <= nxt_svc;
	end

	// Pending request, retired by its strobe
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			pend_isr_ff <= trv_pkg::ZERO_BYTE;
		else
			pend_isr_ff <= nxt_pend_isr;
	end

	// Pending clear, retired by its strobe
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			pend_clr_ff <= trv_pkg::ZERO_BYTE;
		else
			pend_clr_ff <= nxt_pend_clr;
	end

	// Service strobe, one cycle, only while enabled
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			isr_strobe_o <= trv_pkg::ZERO_BYTE;
		else
			isr_strobe_o <= nxt_isr_strobe;
	end

	// Clear strobe, one cycle, only while enabled
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			clear_strobe_o <= trv_pkg::ZERO_BYTE;
		else
			clear_strobe_o <= nxt_clear_strobe;
	end

	// Missed flags: a new miss wins over a write-one clear
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			missed_request_flags_ff <= trv_pkg::ZERO_BYTE;
		else
			missed_request_flags_ff <= nxt_missed;
	end

	// Single wait-free answer
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req && is_mapped(wb_adr_i);
	end

	// Refusal has no side effect: writes decode only mapped offsets
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			wb_err_o <= 1'b0;
		else
			wb_err_o <= wb_req && !is_mapped(wb_adr_i);
	end

	// Read data stands with ack only, zero otherwise
	always_ff @(posedge clk_i)
	begin
		if (rst_int)
			wb_dat_o <= trv_pkg::ZERO_WORD;
		else if (wb_req && !wb_we_i)
			wb_dat_o <= rd_word(wb_adr_i);
		else
			wb_dat_o <= trv_pkg::ZERO_WORD;
	end
endmodule
`default_nettype wire

// ### bench/trv_ret_model.sv
/*
 Decoder model: answers service strobes with interrupt returns.
 Assumes ret_en_i from the bench: low stalls every routine, high returns one clock after each strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module trv_ret_model (
	// Clock and control
	input wire logic clk_i,
	input wire logic ret_en_i,
	// Decoder side
	input wire logic [7:0] isr_strobe_i,
	output logic [7:0] irt_o
);
	logic [7:0] busy_ff = 8'h00;
	// Stalled routines are remembered so a late return still matches a strobe
	always_ff @(posedge clk_i)
	begin
		busy_ff <= ret_en_i ? 8'h00 : (busy_ff | isr_strobe_i);
		irt_o <= ret_en_i ? (busy_ff | isr_strobe_i) : 8'h00;
	end
endmodule
`default_nettype wire

// ### bench/trv_vector_ctrl_props.sv
/*
 Port checker for the thread vector block.
 Assumes the block's own ports only; bound to every instance.
*/
`timescale 1ns/1ps
`default_nettype none
module trv_vector_ctrl_props (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Decoder side
	input wire logic vec_en_i,
	input wire logic [7:0] clear_strobe_o,
	input wire logic [7:0] isr_strobe_o,
	input wire logic core_rst_o,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o
);
	logic req;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !core_rst_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_ACK_RESP: assert property (req |=> wb_ack_o || wb_err_o)
		else $error("no answer");
	AST_ERR_MAP: assert property (req && !(wb_adr_i inside {4'h0, 4'h8, 4'hC})
		|=> wb_err_o && !wb_ack_o)
		else $error("unmapped not refused");
	AST_RD_ZERO: assert property (wb_dat_o != 32'h0 |-> wb_ack_o)
		else $error("read data without ack");
	AST_ISR_PULSE: assert property (isr_strobe_o != 8'h00 |=>
		(isr_strobe_o & $past(isr_strobe_o)) == 8'h00) else $error("strobe repeated");
	AST_CLR_WR: assert property (wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[3]
		&& vec_en_i && $past(vec_en_i) |-> ##1 (clear_strobe_o & $past(wb_dat_i[31:24]))
		== $past(wb_dat_i[31:24])) else $error("clear strobe missing");
	AST_RST_QUIET: assert property (core_rst_o |-> !wb_ack_o && isr_strobe_o == 8'h00
		&& clear_strobe_o == 8'h00) else $error("activity in reset");
	AST_RST_BRIDGE: assert property ($fell(rst_i) |-> core_rst_o ##1 core_rst_o)
		else $error("reset released early");
	cover property (isr_strobe_o != 8'h00);
	cover property (clear_strobe_o == 8'hFF);
	cover property (wb_err_o);
endmodule
bind trv_vector_ctrl trv_vector_ctrl_props trv_vector_ctrl_props_i (.*);
`default_nettype wire

// ### bench/trv_vector_ctrl_tb_top.sv
/*
 Testbench: Wishbone task sequences for the thread vector block.
 Assumes the decoder model and a 200 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module trv_vector_ctrl_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cclr = 1'b0;
	logic ret_en = 1'b0;
	logic ven = 1'b1;
	logic [3:0] sel = 4'hF;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic ack, err, crst;
	logic [7:0] xsr = 8'h00;
	logic [7:0] irt, clr_s, isr_s, is, cs;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0, q;
	int miscompares = 0;
	int tests_run = 0;
	always #2.5 clk_i = ~clk_i;
	trv_vector_ctrl trv_vector_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .core_clear_i(cclr),
		.xsr_req_i(xsr), .vec_en_i(ven), .interrupt_return_op_i(irt), .clear_strobe_o(clr_s),
		.isr_strobe_o(isr_s), .core_rst_o(crst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack),
		.wb_err_o(err));
	trv_ret_model trv_ret_model_i (.clk_i(clk_i), .ret_en_i(ret_en), .isr_strobe_i(isr_s),
		.irt_o(irt));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// Reads compare against d; x is the expected refusal
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic x);
		int i;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		i = 0;
		do
		begin
			@(posedge clk_i);
			i++;
		end
		while (!(ack || err) && i < 20);
		if (i == 20)
		begin
			miscompares++;
			end_of_test();
		end
		chk("err", {31'h0, x}, {31'h0, err});
		if (!w && !x)
			chk("read", d, q);
		cyc <= 1'b0;
	endtask
	// Strobes stand one cycle, so every edge is sampled
	task automatic watch(input int n);
		is = 8'h00;
		cs = 8'h00;
		repeat (n)
		begin
			@(posedge clk_i);
			is |= isr_s;
			cs |= clr_s;
		end
	endtask
	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk("core rst", 32'h0, {31'h0, crst});
		acc(1'b0, 4'h0, 32'h0000FF00, 1'b0);
		acc(1'b1, 4'h0, 32'h000000FF, 1'b0);
		acc(1'b0, 4'h0, 32'h000000FF, 1'b0);
		acc(1'b1, 4'h0, 32'h00000101, 1'b0);
		acc(1'b0, 4'h0, 32'h000001FE, 1'b0);
		$display("arm test end");
		acc(1'b1, 4'h0, 32'h00020000, 1'b0);
		watch(10);
		chk("isr", 32'h02, {24'h0, is});
		acc(1'b0, 4'h0, 32'h000201FE, 1'b0);
		acc(1'b1, 4'h0, 32'h00030000, 1'b0);
		watch(10);
		chk("isr busy", 32'h00, {24'h0, is});
		acc(1'b0, 4'h8, 32'h02000000, 1'b0);
		acc(1'b1, 4'h8, 32'hFF000000, 1'b0);
		acc(1'b0, 4'h8, 32'h00000000, 1'b0);
		ret_en <= 1'b1;
		watch(4);
		acc(1'b0, 4'h0, 32'h000001FE, 1'b0);
		$display("service test end");
		acc(1'b1, 4'h0, 32'h04040000, 1'b0);
		watch(10);
		chk("clr", 32'h04, {24'h0, cs});
		chk("isr clr", 32'h00, {24'h0, is});
		acc(1'b0, 4'h0, 32'h000005FA, 1'b0);
		xsr <= 8'h08;
		watch(20);
		chk("xsr", 32'h08, {24'h0, is});
		xsr <= 8'h00;
		cclr <= 1'b1;
		watch(12);
		acc(1'b0, 4'hC, 32'h00000001, 1'b0);
		cclr <= 1'b0;
		chk("core clr", 32'hFF, {24'h0, cs});
		watch(10);
		acc(1'b0, 4'h0, 32'h0000FF00, 1'b0);
		acc(1'b0, 4'h4, 32'h00000000, 1'b1);
		sel <= 4'h1;
		acc(1'b1, 4'h0, 32'h0000FF01, 1'b0);
		sel <= 4'hF;
		acc(1'b0, 4'h0, 32'h0000FE01, 1'b0);
		ven <= 1'b0;
		acc(1'b1, 4'h0, 32'h00010000, 1'b0);
		watch(6);
		chk("isr off", 32'h00, {24'h0, is});
		ven <= 1'b1;
		acc(1'b1, 4'h0, 32'h00010000, 1'b0);
		watch(6);
		chk("isr on", 32'h01, {24'h0, is});
		$display("clear test end");
		end_of_test();
	end
endmodule
`default_nettype wire
